// ===== fws_pkg.sv
// fault and warning supervision: shared constants, states and signal bundles
// assumes a single 100 MHz clock domain; no registers of its own, only constants and types
`default_nettype none

package fws_pkg;

	// -------------------------------------------------
	// timing
	// -------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int RAMP_MS = 5;
	// longest allowed time, so rounded down
	localparam int RAMP_CYCLES = (CLK_HZ / 1000) * RAMP_MS;
	localparam int CNT_W = 20;

	// -------------------------------------------------
	// widths and field positions
	// -------------------------------------------------
	localparam int NCH = 4;
	localparam int CLIP_W = 8;
	localparam logic [CLIP_W-1:0] CLIP_WIN_DEFAULT = 8'h14;
	localparam int FM_CHAN = 0;
	localparam int FM_OVERTEMP_SHUTDOWN = 1;
	localparam int FM_VOLT = 2;
	localparam int FM_CLK = 3;
	localparam int WM_CLIP = 0;
	localparam int WM_OTW = 1;

	// -------------------------------------------------
	// types
	// -------------------------------------------------
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_HIZ,
		ST_MUTE,
		ST_PLAY,
		ST_RAMP
	} fws_state_e;

	// live conditions from the analog monitors
	typedef struct packed {
		logic vbat_uv;
		logic output_stage_supply_uv;
		logic output_stage_supply_ov;
		logic overtemp_shutdown;
		logic overtemp_warning;
		logic clk_err;
		logic [NCH-1:0] otw_ch;
		logic [NCH-1:0] ocp;
		logic [NCH-1:0] dc;
		logic [NCH-1:0] ilim;
	} fws_cond_s;

	// status flags, sticky except clip when clip_latch is off
	typedef struct packed {
		fws_cond_s cond;
		logic por;
		logic [NCH-1:0] clip;
	} fws_status_s;

	typedef struct packed {
		logic clip_latch;
		logic [CLIP_W-1:0] clip_window;
		logic [3:0] fault_mask;
		logic [1:0] warn_mask;
		logic [1:0] otw_sel;
	} fws_cfg_s;

endpackage

`default_nettype wire

// ===== fws_clip_det.sv
// clip detector: counts consecutive pwm clocks at full modulation per channel
// assumes i_full and i_pwm_tick come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none

module fws_clip_det
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// modulator side
	input wire logic i_pwm_tick,
	input wire logic [fws_pkg::NCH-1:0] i_full,
	input wire logic [fws_pkg::CLIP_W-1:0] i_window,
	// result
	output logic [fws_pkg::NCH-1:0] o_hit
);

	typedef struct packed {
		logic [fws_pkg::NCH-1:0][fws_pkg::CLIP_W-1:0] cnt;
		logic [fws_pkg::NCH-1:0] hit;
	} fws_clip_s;

	fws_clip_s s;
	fws_clip_s next_s;

	// -------------------------------------------------
	// per channel run counter
	// -------------------------------------------------
	always_comb
	begin
		next_s = s;
		for (int i = 0; i < fws_pkg::NCH; i++)
		begin
			if (!i_full[i])
			begin
				next_s.cnt[i] = '0;
			end
			else if (i_pwm_tick && (s.cnt[i] != {fws_pkg::CLIP_W{1'b1}}))
			begin
				next_s.cnt[i] = s.cnt[i] + 1'b1;
			end
			// flagged once the run reaches the window; drops as soon as full ends
			next_s.hit[i] = i_full[i] && (next_s.cnt[i] >= i_window); // see (R11)
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign o_hit = s.hit;

endmodule // fws_clip_det

`default_nettype wire

// ===== fws_top.sv
// fault and warning supervision with pin control of the operating state
// assumes monitor and pin inputs are asynchronous; config and clear come from
// register logic on i_ref_clk; i_rst is the logic supply power-on reset
//
// Notes on behaviour
// (R1) undervoltage on battery or output supply asserts fault pin and sets flag
// (R2) power-on reset disables control interface and resets all state to default
// (R3) after power-on reset the reset warning flag and warning pin are set
// (R4) output supply overvoltage asserts fault pin and sets its flag
// (R5) host holds standby low at least 15 ms before removing supplies; the host model holds it 30 clocks
// (R6) fault pin driven by channel, thermal shutdown, supply and clock faults
// (R7) fault pin stays latched until the clear-fault pulse
// (R8) fault flags are sticky until the clear-fault pulse
// (R9) fault masks gate only the pin; all categories reach pin by default
// (R10) warning pin reports clip, overtemp warning, current limit and reset
// (R11) clip flagged after programmable run of full pwm clocks, default 20
// (R12) in latching clip mode the clip flag holds until clear-fault
// (R13) overtemp warning from global or any channel warning; threshold selectable
// (R14) warning masks gate clip or overtemp from pin without touching flags
// (R15) warning pin latched until the clear-fault pulse
// (R16) mute pin low mutes all channels, high unmutes
// (R17) standby low shuts down, ramping active outputs down within 5 ms
// (R18) four states: standby, hi-z, mute at 50 percent, play
// (R19) reset forces standby; supply and thermal shutdown force hi-z
// (R20) channel overcurrent and dc faults in mute and play put channel hi-z
// (R21) clear-fault is a one-cycle pulse clearing all sticky state
`timescale 1ns/10ps
`default_nettype none

module fws_top
#(
	parameter int RAMP_CYCLES = fws_pkg::RAMP_CYCLES
)
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// control pins, active low
	input wire logic i_mute_n,
	input wire logic i_standby_n,
	// analog monitor conditions
	input wire fws_pkg::fws_cond_s i_cond,
	// modulator side
	input wire logic i_pwm_tick,
	input wire logic [fws_pkg::NCH-1:0] i_pwm_full,
	// configuration and clear pulse
	input wire fws_pkg::fws_cfg_s i_cfg,
	input wire fws_pkg::fws_state_e i_state_req,
	input wire logic i_clear_fault,
	// status
	output fws_pkg::fws_status_s o_status,
	output fws_pkg::fws_state_e o_state,
	output logic o_ctl_en,
	output logic [1:0] o_otw_sel,
	// output stage control
	output logic [fws_pkg::NCH-1:0] o_ch_hiz,
	output logic o_ch_mute,
	output logic o_ramp_down,
	output logic o_osc_run,
	// open-drain pins
	output logic o_fault_out,
	output logic o_fault_oe,
	output logic o_warn_out,
	output logic o_warn_oe
);

	typedef struct packed {
		fws_pkg::fws_cond_s cond_m;
		fws_pkg::fws_cond_s cond_q;
		logic [1:0] pin_m;
		logic [1:0] pin_q;
		fws_pkg::fws_status_s st;
		fws_pkg::fws_state_e state;
		logic [fws_pkg::CNT_W-1:0] cnt;
		logic [fws_pkg::NCH-1:0] ch_flt;
		logic glob_hold;
		logic fault_lat;
		logic warn_lat;
		logic ctl_en;
		logic [1:0] otw_sel;
		logic [fws_pkg::NCH-1:0] ch_hiz;
		logic ch_mute;
		logic osc_run;
		logic ramp;
	} fws_top_s;

	localparam logic [fws_pkg::CNT_W-1:0] RAMP_LAST = fws_pkg::CNT_W'(RAMP_CYCLES - 1);

	fws_top_s s;
	fws_top_s next_s;
	logic [fws_pkg::NCH-1:0] clip_hit;

	// -------------------------------------------------
	// clip detection
	// -------------------------------------------------
	fws_clip_det u_clip
	(
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_pwm_tick(i_pwm_tick),
		.i_full(i_pwm_full),
		.i_window(i_cfg.clip_window),
		.o_hit(clip_hit)
	);

	// -------------------------------------------------
	// state selection helper
	// -------------------------------------------------
	function automatic fws_pkg::fws_state_e pick_run(input fws_pkg::fws_state_e req, input logic mute_n);
		fws_pkg::fws_state_e r;
		r = fws_pkg::ST_HIZ;
		if (req == fws_pkg::ST_PLAY)
		begin
			r = mute_n ? fws_pkg::ST_PLAY : fws_pkg::ST_MUTE; // see (R16)
		end
		else if (req == fws_pkg::ST_MUTE)
		begin
			r = fws_pkg::ST_MUTE;
		end
		return r;
	endfunction

	// -------------------------------------------------
	// next state
	// -------------------------------------------------
	always_comb
	begin
		fws_pkg::fws_cond_s c;
		logic clr;
		logic mute_n;
		logic stby_n;
		logic mon_glob;
		logic mon_ch;
		logic [fws_pkg::NCH-1:0] ch_ev;
		logic volt_ev;
		logic otw_any;
		logic fault_ev;
		logic warn_ev;
		fws_pkg::fws_state_e run;

		next_s = s;
		c = s.cond_q;
		clr = i_clear_fault; // see (R21)
		mute_n = s.pin_q[0];
		stby_n = s.pin_q[1];
		mon_glob = 1'b0;
		mon_ch = 1'b0;
		ch_ev = '0;
		volt_ev = 1'b0;
		otw_any = 1'b0;
		fault_ev = 1'b0;
		warn_ev = 1'b0;
		run = fws_pkg::ST_HIZ;

		// two-stage synchronisers for pins and monitors
		next_s.cond_m = i_cond;
		next_s.cond_q = s.cond_m;
		next_s.pin_m = {i_standby_n, i_mute_n};
		next_s.pin_q = s.pin_m;

		// monitoring windows per operating state
		mon_glob = (s.state != fws_pkg::ST_STANDBY); // see (R19)
		mon_ch = (s.state == fws_pkg::ST_MUTE) || (s.state == fws_pkg::ST_PLAY); // see (R20)
		c.vbat_uv = c.vbat_uv & mon_glob;
		c.output_stage_supply_uv = c.output_stage_supply_uv & mon_glob;
		c.output_stage_supply_ov = c.output_stage_supply_ov & mon_glob;
		c.overtemp_shutdown = c.overtemp_shutdown & mon_glob;
		c.overtemp_warning = c.overtemp_warning & mon_glob;
		c.otw_ch = c.otw_ch & {fws_pkg::NCH{mon_glob}};
		c.ocp = c.ocp & {fws_pkg::NCH{mon_ch}};
		c.dc = c.dc & {fws_pkg::NCH{mon_ch}};

		// sticky flags, a new event wins over the clear
		next_s.st.cond = (clr ? '0 : s.st.cond) | c; // see (R1) see (R4) see (R8)
		next_s.st.por = clr ? 1'b0 : s.st.por; // see (R3)
		if (i_cfg.clip_latch)
		begin
			next_s.st.clip = (clr ? '0 : s.st.clip) | clip_hit; // see (R12)
		end
		else
		begin
			next_s.st.clip = clip_hit;
		end

		// fault pin, categories gated by masks only
		ch_ev = c.ocp | c.dc;
		volt_ev = c.vbat_uv | c.output_stage_supply_uv | c.output_stage_supply_ov;
		fault_ev = ((|ch_ev) & ~i_cfg.fault_mask[fws_pkg::FM_CHAN])
			| (c.overtemp_shutdown & ~i_cfg.fault_mask[fws_pkg::FM_OVERTEMP_SHUTDOWN])
			| (volt_ev & ~i_cfg.fault_mask[fws_pkg::FM_VOLT])
			| (c.clk_err & ~i_cfg.fault_mask[fws_pkg::FM_CLK]); // see (R6) see (R9)
		next_s.fault_lat = (clr ? 1'b0 : s.fault_lat) | fault_ev; // see (R7)

		// warning pin
		otw_any = c.overtemp_warning | (|c.otw_ch); // see (R13)
		warn_ev = ((|clip_hit) & ~i_cfg.warn_mask[fws_pkg::WM_CLIP])
			| (otw_any & ~i_cfg.warn_mask[fws_pkg::WM_OTW])
			| (|c.ilim); // see (R10) see (R14)
		next_s.warn_lat = (clr ? 1'b0 : s.warn_lat) | warn_ev; // see (R15)

		// protective holds
		next_s.ch_flt = (clr ? '0 : s.ch_flt) | ch_ev; // see (R20)
		next_s.glob_hold = (clr ? 1'b0 : s.glob_hold) | volt_ev | c.overtemp_shutdown | c.clk_err; // see (R19)

		// operating state
		run = pick_run(i_state_req, mute_n);
		case (s.state)
			fws_pkg::ST_STANDBY:
			begin
				next_s.cnt = '0;
				if (stby_n)
				begin
					next_s.state = fws_pkg::ST_HIZ;
				end
			end
			fws_pkg::ST_HIZ:
			begin
				if (!stby_n)
				begin
					next_s.state = fws_pkg::ST_STANDBY; // see (R17)
				end
				else if (!next_s.glob_hold)
				begin
					next_s.state = run;
				end
			end
			fws_pkg::ST_MUTE, fws_pkg::ST_PLAY:
			begin
				next_s.cnt = '0;
				if (!stby_n)
				begin
					next_s.state = fws_pkg::ST_RAMP; // see (R17)
				end
				else if (next_s.glob_hold)
				begin
					next_s.state = fws_pkg::ST_HIZ; // see (R19)
				end
				else
				begin
					next_s.state = run; // see (R16)
				end
			end
			fws_pkg::ST_RAMP:
			begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt >= RAMP_LAST)
				begin
					next_s.state = fws_pkg::ST_STANDBY; // see (R17)
				end
			end
			default:
			begin
				next_s.state = fws_pkg::ST_STANDBY;
			end
		endcase

		// registered outputs follow the next state
		next_s.ctl_en = 1'b1; // see (R2)
		next_s.otw_sel = i_cfg.otw_sel; // see (R13)
		next_s.osc_run = (next_s.state != fws_pkg::ST_STANDBY); // see (R18)
		next_s.ramp = (next_s.state == fws_pkg::ST_RAMP); // see (R17)
		next_s.ch_mute = (next_s.state == fws_pkg::ST_MUTE); // see (R18)
		if ((next_s.state == fws_pkg::ST_STANDBY) || (next_s.state == fws_pkg::ST_HIZ))
		begin
			next_s.ch_hiz = '1; // see (R18)
		end
		else
		begin
			next_s.ch_hiz = next_s.ch_flt; // see (R20)
		end
	end

	// -------------------------------------------------
	// state register
	// -------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s <= '0; // see (R2) see (R19)
			s.st.por <= 1'b1; // see (R3)
			s.warn_lat <= 1'b1; // see (R3)
			s.ch_hiz <= '1;
		end
		else
		begin
			s <= next_s;
		end
	end

	// -------------------------------------------------
	// outputs
	// -------------------------------------------------
	assign o_status = s.st;
	assign o_state = s.state;
	assign o_ctl_en = s.ctl_en;
	assign o_otw_sel = s.otw_sel;
	assign o_ch_hiz = s.ch_hiz;
	assign o_ch_mute = s.ch_mute;
	assign o_ramp_down = s.ramp;
	assign o_osc_run = s.osc_run;
	// open drain: only ever pulls low
	assign o_fault_out = 1'b0;
	assign o_fault_oe = s.fault_lat;
	assign o_warn_out = 1'b0;
	assign o_warn_oe = s.warn_lat;

endmodule // fws_top

`default_nettype wire

// ===== fws_top_monitor.sv
// checker for the fault and warning supervision block
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module fws_top_monitor
#(
	parameter int RAMP_CYCLES = fws_pkg::RAMP_CYCLES
)
(
	// watched inputs
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_mute_n,
	input wire fws_pkg::fws_cond_s i_cond,
	input wire logic [fws_pkg::NCH-1:0] i_pwm_full,
	input wire logic i_clear_fault,
	// watched outputs
	input wire fws_pkg::fws_status_s o_status,
	input wire fws_pkg::fws_state_e o_state,
	input wire logic [fws_pkg::NCH-1:0] o_ch_hiz,
	input wire logic o_ramp_down,
	input wire logic o_osc_run,
	input wire logic o_fault_oe,
	input wire logic o_warn_oe
);
	int ramp_cnt;
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
			ramp_cnt <= 0;
		else
			ramp_cnt <= o_ramp_down ? ramp_cnt + 1 : 0;
	default clocking dc @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	a_por_warn_set: assert property ($past(i_rst) |-> o_status.por && o_warn_oe)
		else $error("reset warning missing");
	a_fault_pin_held: assert property (o_fault_oe && !i_clear_fault |=> o_fault_oe)
		else $error("fault pin released");
	a_warn_pin_held: assert property (o_warn_oe && !i_clear_fault |=> o_warn_oe)
		else $error("warn pin released");
	a_flags_sticky: assert property (!i_clear_fault |=> ($past(o_status.cond) & ~o_status.cond) == '0)
		else $error("flag dropped");
	a_fault_has_cause: assert property ($rose(o_fault_oe) |-> o_status.cond.vbat_uv || o_status.cond.output_stage_supply_uv
		|| o_status.cond.output_stage_supply_ov || o_status.cond.overtemp_shutdown || o_status.cond.clk_err || o_status.cond.ocp != '0
		|| o_status.cond.dc != '0) else $error("fault pin without fault");
	a_clear_all: assert property ((i_cond == '0 && i_pwm_full == '0)[*3] ##0 i_clear_fault
		|=> !o_fault_oe && !o_warn_oe && o_status == '0) else $error("clear incomplete");
	a_mute_no_play: assert property ((!i_mute_n)[*4] |-> o_state != fws_pkg::ST_PLAY)
		else $error("play while muted");
	a_standby_dark: assert property (o_state == fws_pkg::ST_STANDBY |-> !o_osc_run && o_ch_hiz == 4'hf)
		else $error("standby not dark");
	a_ramp_bound: assert property (ramp_cnt <= RAMP_CYCLES)
		else $error("ramp too long");
endmodule // fws_top_monitor
bind fws_top fws_top_monitor #(.RAMP_CYCLES(RAMP_CYCLES)) fws_top_monitor_i (.i_ref_clk, .i_rst, .i_mute_n,
	.i_cond, .i_pwm_full, .i_clear_fault, .o_status, .o_state, .o_ch_hiz, .o_ramp_down, .o_osc_run,
	.o_fault_oe, .o_warn_oe);
`default_nettype wire

// ===== fws_host.sv
// host controller model: control pins and the clear pulse
// assumes tasks are called from the bench on the same clock
`timescale 1ns/10ps
`default_nettype none
module fws_host
#(
	parameter int HOLD = 30
)
(
	input wire logic i_ref_clk,
	output logic o_mute_n,
	output logic o_standby_n,
	output logic o_clear_fault,
	output logic o_supply_on
);
	initial
	begin
		o_mute_n = 1'b1;
		o_standby_n = 1'b0;
		o_clear_fault = 1'b0;
		o_supply_on = 1'b1;
	end
	task automatic pins(input logic m, input logic s);
		@(posedge i_ref_clk);
		#1 o_mute_n = m;
		o_standby_n = s;
	endtask
	task automatic clr();
		@(posedge i_ref_clk);
		#1 o_clear_fault = 1'b1;
		@(posedge i_ref_clk);
		#1 o_clear_fault = 1'b0;
	endtask
	// supplies drop only after standby has been held low long enough
	task automatic off();
		pins(o_mute_n, 1'b0);
		repeat (HOLD) @(posedge i_ref_clk);
		#1 o_supply_on = 1'b0;
	endtask
endmodule // fws_host
`default_nettype wire

// ===== fws_top_tb.sv
// self-checking bench for the fault and warning supervision block
// assumes a shortened ramp count and a host model on the pins
`timescale 1ns/10ps
`default_nettype none
module fws_top_tb;
	localparam int RC = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mute_n, sb_n, clr, pwr, tick, ctl, ramp, osc, foe, woe, ef, ew, fo, wo, mute;
	logic [1:0] otw_sel;
	logic [3:0] full, hiz, eh;
	logic [21:0] ex;
	fws_pkg::fws_cond_s cond;
	fws_pkg::fws_cfg_s cfg;
	fws_pkg::fws_state_e req, state;
	fws_pkg::fws_status_s st;
	int miscompares = 0, total_checks = 0, seed = 95031, b, w, f;
	always #5 clk = ~clk;
	fws_host #(.HOLD(30)) fws_host_i (.i_ref_clk(clk), .o_mute_n(mute_n), .o_standby_n(sb_n),
		.o_clear_fault(clr), .o_supply_on(pwr));
	fws_top #(.RAMP_CYCLES(RC)) fws_top_i (.i_ref_clk(clk), .i_rst(rst), .i_mute_n(mute_n),
		.i_standby_n(sb_n), .i_cond(cond), .i_pwm_tick(tick), .i_pwm_full(full), .i_cfg(cfg),
		.i_state_req(req), .i_clear_fault(clr), .o_status(st), .o_state(state), .o_ctl_en(ctl),
		.o_otw_sel(otw_sel), .o_ch_hiz(hiz), .o_ch_mute(mute), .o_ramp_down(ramp), .o_osc_run(osc),
		.o_fault_out(fo), .o_fault_oe(foe), .o_warn_out(wo), .o_warn_oe(woe));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			miscompares++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#50000;
		miscompares++;
		wrap_up();
	end
	initial
	begin
		cond = '0;
		cfg = '0;
		cfg.clip_window = fws_pkg::CLIP_WIN_DEFAULT;
		req = fws_pkg::ST_PLAY;
		full = '0;
		tick = 1'b0;
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		cyc(1);
		chk(st, 27'h1 << 4);
		chk({woe, foe, ctl, osc, mute, ramp, state}, {6'b101000, fws_pkg::ST_STANDBY});
		fws_host_i.pins(1'b1, 1'b1);
		cyc(5);
		chk({mute, osc, hiz, state}, {6'b010000, fws_pkg::ST_PLAY});
		fws_host_i.clr();
		chk({st, woe}, '0);
		for (b = 0; b < 22; b++)
		begin
			cfg.fault_mask = 4'($random(seed));
			cfg.warn_mask = 2'($random(seed));
			cfg.otw_sel = 2'($random(seed));
			cond = fws_pkg::fws_cond_s'(22'(1) << b);
			cyc(1);
			cond = '0;
			cyc(4);
			ex = 22'(1) << b;
			f = b > 18 ? fws_pkg::FM_VOLT : b == 18 ? fws_pkg::FM_OVERTEMP_SHUTDOWN : b == 16 ? fws_pkg::FM_CLK
				: (b > 3 && b < 12) ? fws_pkg::FM_CHAN : -1;
			ef = f >= 0 && !cfg.fault_mask[f];
			ew = f < 0 && (b < 4 || !cfg.warn_mask[fws_pkg::WM_OTW]);
			eh = (b > 17 || b == 16) ? 4'hf : (f == fws_pkg::FM_CHAN) ? 4'(1 << (b % 4)) : 4'h0;
			chk(st.cond, ex);
			chk({fo, wo, foe, woe}, {2'b00, ef, ew});
			chk(otw_sel, cfg.otw_sel);
			chk(hiz, eh);
			fws_host_i.clr();
			chk({st, foe, woe}, '0);
			cyc(6);
			chk({hiz, state}, {4'h0, fws_pkg::ST_PLAY});
		end
		w = 3 + $unsigned($random(seed)) % 8;
		cfg.clip_window = 8'(w);
		cfg.clip_latch = 1'b1;
		cfg.warn_mask = '0;
		full = 4'(1 << ($unsigned($random(seed)) % 4));
		tick = 1'b1;
		cyc(w - 1);
		tick = 1'b0;
		cyc(3);
		chk({st.clip, woe}, 5'h0);
		tick = 1'b1;
		cyc(1);
		tick = 1'b0;
		cyc(3);
		chk({st.clip, woe}, {full, 1'b1});
		ex = 22'(full);
		full = '0;
		cyc(3);
		chk({st.clip, woe}, {ex[3:0], 1'b1});
		fws_host_i.clr();
		cfg.clip_latch = 1'b0;
		cfg.warn_mask[fws_pkg::WM_CLIP] = 1'b1;
		full = ex[3:0];
		tick = 1'b1;
		cyc(w + 3);
		chk({st.clip, woe}, {full, 1'b0});
		full = '0;
		cyc(3);
		chk(st.clip, 4'h0);
		fws_host_i.off();
		chk({pwr, osc, hiz, state}, {6'b001111, fws_pkg::ST_STANDBY});
		fws_host_i.pins(1'b0, 1'b1);
		cyc(6);
		chk({mute, state}, {1'b1, fws_pkg::ST_MUTE});
		fws_host_i.pins(1'b1, 1'b1);
		cyc(5);
		chk({mute, state}, {1'b0, fws_pkg::ST_PLAY});
		req = fws_pkg::ST_MUTE;
		cyc(2);
		chk({mute, hiz, state}, {5'b10000, fws_pkg::ST_MUTE});
		req = fws_pkg::ST_HIZ;
		cyc(2);
		chk({mute, osc, hiz, state}, {6'b011111, fws_pkg::ST_HIZ});
		req = fws_pkg::ST_PLAY;
		cyc(2);
		chk(state, fws_pkg::ST_PLAY);
		rst = 1'b1;
		cyc(2);
		chk({ctl, osc, hiz, state}, {6'b001111, fws_pkg::ST_STANDBY});
		rst = 1'b0;
		cyc(1);
		chk({st.por, woe, ctl, state}, {3'b111, fws_pkg::ST_STANDBY});
		cyc(4);
		chk(state, fws_pkg::ST_PLAY);
		fws_host_i.pins(1'b1, 1'b0);
		cyc(3);
		chk({ramp, state}, {1'b1, fws_pkg::ST_RAMP});
		cyc(RC - 1);
		chk({ramp, hiz}, {1'b1, 4'h0});
		cyc(1);
		chk({ramp, osc, hiz, state}, {6'b001111, fws_pkg::ST_STANDBY});
		wrap_up();
	end
endmodule // fws_top_tb
`default_nettype wire
